// ===== shared/phw_params.svh
`ifndef PHW_PARAMS_SVH
`define PHW_PARAMS_SVH

// Register byte offsets
`define PHW_OFS_ID 4'h0
`define PHW_OFS_CTRL 4'h4
`define PHW_OFS_STAT 4'h8
`define PHW_OFS_LIVE 4'hc

// Identity word layout
`define PHW_PREFIX_HI 15
`define PHW_PREFIX_LO 13
`define PHW_PREFIX 3'h6
`define PHW_BIT_BRAKE 12
`define PHW_BIT_DC_SPECIAL 11
`define PHW_BIT_NO_CONV24 10
`define PHW_BIT_SAFETY 9
`define PHW_BIT_FILTER 8
`define PHW_VOLT_HI 7
`define PHW_VOLT_LO 6
`define PHW_CUR_HI 5
`define PHW_CUR_LO 0

// Supply voltage class codes
`define PHW_VOLT_200_240 2'h0
`define PHW_VOLT_380_480 2'h1

// Control and status bits
`define PHW_CTRL_RECAPTURE 0
`define PHW_CTRL_BLANK 1
`define PHW_STAT_WR_REJECT 0
`define PHW_STAT_UNMAPPED 1
`define PHW_STAT_MISMATCH 2

// Reset values
`define PHW_ID_RESET 16'hc000
`define PHW_CTRL_RESET 1'h0
`define PHW_STAT_RESET 1'h0

// Keypad character codes
`define PHW_ASCII_SPACE 8'h20
`define PHW_ASCII_ZERO 8'h30
`define PHW_ASCII_ALPHA 8'h37

`endif

// ===== shared/phw_pkg.sv
package phw_pkg;
    typedef logic [15:0] phw_word_t;
    typedef logic [31:0] phw_chars_t;
    typedef enum logic [1:0] {
        PHW_REG_ID = 2'b00,
        PHW_REG_CTRL = 2'b01,
        PHW_REG_STAT = 2'b10,
        PHW_REG_LIVE = 2'b11
    } phw_reg_t;
endpackage : phw_pkg

// ===== shared/phw_strap_if.sv
`timescale 1ns/1ps
interface phw_strap_if;
    import phw_pkg::*;
    logic capture;
    phw_word_t word;
    phw_word_t live;
    logic mismatch;
    modport assembler (input capture, output word, output live, output mismatch);
    modport owner (output capture, input word, input live, input mismatch);
endinterface : phw_strap_if

// ===== verilog/phw_strap_assembler.sv
`timescale 1ns/1ps
`include "phw_params.svh"
module phw_strap_assembler
    import phw_pkg::*;
(
    input wire logic core_clk, // System clock
    input wire logic arst_n, // Async reset
    input wire logic braking_switch_fitted, // Braking transistor strap
    input wire logic dc_special_fitted, // Special DC hardware strap
    input wire logic conv24_fitted, // External 24 V converter strap
    input wire logic safety_relay_fitted, // Safety relay strap
    input wire logic interference_filter_fitted, // Filter strap
    input wire logic [1:0] voltage_class, // Supply voltage class strap
    input wire logic [5:0] normal_duty_current_code, // Rated current strap
    phw_strap_if.assembler sif // Word towards the register bank
);
    phw_word_t live_word;

    always_comb begin
        live_word = `PHW_ID_RESET;
        live_word[`PHW_PREFIX_HI:`PHW_PREFIX_LO] = `PHW_PREFIX;
        live_word[`PHW_BIT_BRAKE] = ~braking_switch_fitted;
        live_word[`PHW_BIT_DC_SPECIAL] = dc_special_fitted;
        live_word[`PHW_BIT_NO_CONV24] = ~conv24_fitted;
        live_word[`PHW_BIT_SAFETY] = safety_relay_fitted;
        live_word[`PHW_BIT_FILTER] = interference_filter_fitted;
        live_word[`PHW_VOLT_HI:`PHW_VOLT_LO] = voltage_class;
        live_word[`PHW_CUR_HI:`PHW_CUR_LO] = normal_duty_current_code;
    end

    // Word only follows the straps on a capture
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sif.word <= `PHW_ID_RESET;
        end else if (sif.capture) begin
            sif.word <= live_word;
        end
    end

    assign sif.live = live_word;
    assign sif.mismatch = (live_word != sif.word);
endmodule : phw_strap_assembler

// ===== verilog/phw_power_id.sv
// Notes on behaviour
// - Bits 15..13 always read 110
// - Bit 12 low when braking switch fitted
// - Bit 11 high with special DC hardware
// - Bit 10 low when 24 V converter fitted
// - Bit 9 high with safety relay
// - Bit 8 high with interference filter
// - Bits 7..6 give supply voltage class
// - Bits 5..0 give normal duty current code
// - Word shown as four hex keypad digits
// - Identity word is read-only, writes ignored
`timescale 1ns/1ps
`include "phw_params.svh"
module phw_power_id
    import phw_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic core_clk, // System clock, 40 MHz
    input wire logic arst_n, // Async reset, active low
    input wire logic [ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall, high while answer pending
    input wire logic braking_switch_fitted, // Braking transistor strap
    input wire logic dc_special_fitted, // Special DC hardware strap
    input wire logic conv24_fitted, // External 24 V converter strap
    input wire logic safety_relay_fitted, // Safety relay strap
    input wire logic interference_filter_fitted, // Filter strap
    input wire logic [1:0] voltage_class, // Supply voltage class strap
    input wire logic [5:0] normal_duty_current_code, // Rated current strap
    output phw_word_t power_hardware_identity_word, // Captured word
    output phw_chars_t operator_keypad // Four ASCII digits, MSD on top
);
    phw_strap_if sif ();

    phw_strap_assembler u_assembler (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .braking_switch_fitted(braking_switch_fitted),
        .dc_special_fitted(dc_special_fitted),
        .conv24_fitted(conv24_fitted),
        .safety_relay_fitted(safety_relay_fitted),
        .interference_filter_fitted(interference_filter_fitted),
        .voltage_class(voltage_class),
        .normal_duty_current_code(normal_duty_current_code),
        .sif(sif.assembler)
    );

    function automatic logic [7:0] hex_char(input logic [3:0] nib);
        logic [7:0] ext;
        ext = {4'h0, nib};
        if (nib < 4'ha) begin
            hex_char = `PHW_ASCII_ZERO + ext;
        end else begin
            hex_char = `PHW_ASCII_ALPHA + ext;
        end
    endfunction : hex_char

    function automatic phw_chars_t word_chars(input phw_word_t w);
        word_chars = {hex_char(w[15:12]), hex_char(w[11:8]),
                      hex_char(w[7:4]), hex_char(w[3:0])};
    endfunction : word_chars

    // Bus decode
    logic req;
    logic ack;
    logic mapped;
    phw_reg_t reg_sel;
    logic sel_id;
    logic sel_ctrl;
    logic sel_stat;
    logic wr_done;
    logic wr_id;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_unmapped;
    logic rd_unmapped;

    assign req = avs_read | avs_write;
    assign reg_sel = phw_reg_t'(avs_address[3:2]);
    assign mapped = ((avs_address >> 4) == '0) && (avs_address[1:0] == 2'b00);
    assign sel_id = mapped && (reg_sel == PHW_REG_ID);
    assign sel_ctrl = mapped && (reg_sel == PHW_REG_CTRL);
    assign sel_stat = mapped && (reg_sel == PHW_REG_STAT);
    assign wr_done = avs_write && ack;
    assign wr_id = wr_done && sel_id;
    assign wr_ctrl = wr_done && sel_ctrl && avs_byteenable[0];
    assign wr_stat = wr_done && sel_stat && avs_byteenable[0];
    assign wr_unmapped = wr_done && !mapped;
    assign rd_unmapped = avs_read && ack && !mapped;

    // One wait state, answer on the second edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    assign avs_waitrequest = req && !ack;

    // Control register
    logic recapture;
    logic keypad_blank;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            recapture <= `PHW_CTRL_RESET;
            keypad_blank <= `PHW_CTRL_RESET;
        end else begin
            recapture <= wr_ctrl && avs_writedata[`PHW_CTRL_RECAPTURE];
            if (wr_ctrl) begin
                keypad_blank <= avs_writedata[`PHW_CTRL_BLANK];
            end
        end
    end

    // Straps caught once after reset release, then only on request
    logic boot_done;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_done <= 1'b0;
        end else begin
            boot_done <= 1'b1;
        end
    end

    assign sif.capture = !boot_done || recapture;

    // Sticky status, set wins over write-one-to-clear
    logic wr_reject;
    logic unmapped_hit;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_reject <= `PHW_STAT_RESET;
        end else if (wr_id) begin
            wr_reject <= 1'b1;
        end else if (wr_stat && avs_writedata[`PHW_STAT_WR_REJECT]) begin
            wr_reject <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            unmapped_hit <= `PHW_STAT_RESET;
        end else if (wr_unmapped || rd_unmapped) begin
            unmapped_hit <= 1'b1;
        end else if (wr_stat && avs_writedata[`PHW_STAT_UNMAPPED]) begin
            unmapped_hit <= 1'b0;
        end
    end

    // Read data, latched on the first edge of a read
    logic [31:0] next_readdata;

    always_comb begin
        next_readdata = '0;
        if (mapped) begin
            case (reg_sel)
                PHW_REG_ID: begin
                    next_readdata[15:0] = sif.word;
                end
                PHW_REG_CTRL: begin
                    next_readdata[`PHW_CTRL_BLANK] = keypad_blank;
                end
                PHW_REG_STAT: begin
                    next_readdata[`PHW_STAT_WR_REJECT] = wr_reject;
                    next_readdata[`PHW_STAT_UNMAPPED] = unmapped_hit;
                    next_readdata[`PHW_STAT_MISMATCH] = sif.mismatch;
                end
                PHW_REG_LIVE: begin
                    next_readdata[15:0] = sif.live;
                end
                default: begin
                    next_readdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_readdata;
        end
    end

    // Keypad digits and word output
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            operator_keypad <= {4{`PHW_ASCII_SPACE}};
        end else if (keypad_blank) begin
            operator_keypad <= {4{`PHW_ASCII_SPACE}};
        end else begin
            operator_keypad <= word_chars(sif.word);
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_hardware_identity_word <= `PHW_ID_RESET;
        end else begin
            power_hardware_identity_word <= sif.word;
        end
    end

    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    AST_PREFIX: assert property (
        power_hardware_identity_word[`PHW_PREFIX_HI:`PHW_PREFIX_LO] == `PHW_PREFIX
    ) else $error("identity prefix is not 110");

    AST_BRAKE_INVERTED: assert property (
        (sif.capture && arst_n) |=> sif.word[`PHW_BIT_BRAKE] == !$past(braking_switch_fitted)
    ) else $error("braking bit does not show inverted strap");

    AST_DC_SPECIAL: assert property (
        (sif.capture && arst_n) |=> sif.word[`PHW_BIT_DC_SPECIAL] == $past(dc_special_fitted)
    ) else $error("special DC bit does not follow strap");

    AST_CONV24_INVERTED: assert property (
        (sif.capture && arst_n) |=> sif.word[`PHW_BIT_NO_CONV24] == !$past(conv24_fitted)
    ) else $error("24 V converter bit does not show inverted strap");

    AST_SAFETY_RELAY: assert property (
        (sif.capture && arst_n) |=> sif.word[`PHW_BIT_SAFETY] == $past(safety_relay_fitted)
    ) else $error("safety relay bit does not follow strap");

    AST_FILTER: assert property (
        (sif.capture && arst_n) |=> sif.word[`PHW_BIT_FILTER] == $past(interference_filter_fitted)
    ) else $error("filter bit does not follow strap");

    AST_VOLTAGE: assert property (
        (sif.capture && arst_n) |=> sif.word[`PHW_VOLT_HI:`PHW_VOLT_LO] == $past(voltage_class)
    ) else $error("voltage class field does not follow strap");

    AST_CURRENT: assert property (
        (sif.capture && arst_n)
            |=> sif.word[`PHW_CUR_HI:`PHW_CUR_LO] == $past(normal_duty_current_code)
    ) else $error("current code field does not follow strap");

    AST_KEYPAD: assert property (
        (!keypad_blank && !sif.capture) ##1 !sif.capture
            |-> operator_keypad == word_chars(sif.word)
    ) else $error("keypad digits do not match identity word");

    AST_READ_ID: assert property (
        (avs_read && sel_id && !ack) |=> avs_readdata[15:0] == $past(sif.word)
            && avs_readdata[31:16] == 16'h0000
    ) else $error("identity read returned wrong data");

    AST_WRITE_IGNORED: assert property (
        (wr_id && !sif.capture) |=> $stable(sif.word) && wr_reject
    ) else $error("write to identity word changed it or went unflagged");

    AST_STABLE: assert property (
        !sif.capture |=> $stable(sif.word)
    ) else $error("identity word changed without a capture");

    AST_ANSWER_BOUND: assert property (
        (req && !ack) |=> !avs_waitrequest || !req
    ) else $error("bus answer did not come on the second edge");

    // Bus handshake shape
    AST_WAIT_FIRST: assert property (
        (req && !ack) |-> avs_waitrequest
    ) else $error("waitrequest low in first request cycle");

    AST_WAIT_RELEASE: assert property (
        (req && ack) |-> !avs_waitrequest
    ) else $error("waitrequest high in answer cycle");

    AST_WAIT_IDLE: assert property (
        !req |-> !avs_waitrequest
    ) else $error("waitrequest high without a request");

    AST_ACK_ONE_CYCLE: assert property (
        ack |=> !ack
    ) else $error("answer stood for more than one cycle");

    AST_READDATA_HOLD: assert property (
        !(avs_read && !ack) |=> $stable(avs_readdata)
    ) else $error("read data changed without a new read");

    // Register contents and sticky status
    AST_UNMAPPED_READ_ZERO: assert property (
        (avs_read && !mapped && !ack) |=> avs_readdata == 32'h0
    ) else $error("unmapped read returned nonzero data");

    AST_UNMAPPED_FLAG: assert property (
        (wr_unmapped || rd_unmapped) |=> unmapped_hit
    ) else $error("unmapped access not flagged");

    AST_UNMAPPED_CLEAR: assert property (
        (wr_stat && avs_writedata[`PHW_STAT_UNMAPPED]) |=> !unmapped_hit
    ) else $error("unmapped flag not cleared by write one");

    AST_REJECT_SET: assert property (
        wr_id |=> wr_reject
    ) else $error("identity write not flagged");

    AST_REJECT_CLEAR: assert property (
        (wr_stat && avs_writedata[`PHW_STAT_WR_REJECT]) |=> !wr_reject
    ) else $error("write reject flag not cleared by write one");

    AST_STAT_READ: assert property (
        (avs_read && sel_stat && !ack)
            |=> avs_readdata[`PHW_STAT_WR_REJECT] == $past(wr_reject)
            && avs_readdata[`PHW_STAT_UNMAPPED] == $past(unmapped_hit)
            && avs_readdata[`PHW_STAT_MISMATCH] == $past(sif.mismatch)
    ) else $error("status read returned wrong flags");

    AST_CTRL_READ: assert property (
        (avs_read && sel_ctrl && !ack)
            |=> avs_readdata[`PHW_CTRL_RECAPTURE] == 1'b0
            && avs_readdata[`PHW_CTRL_BLANK] == $past(keypad_blank)
    ) else $error("control read returned wrong bits");

    AST_READ_LIVE: assert property (
        (avs_read && mapped && reg_sel == PHW_REG_LIVE && !ack)
            |=> avs_readdata == {16'h0000, $past(sif.live)}
    ) else $error("live word read returned wrong data");

    AST_BYTELANE_CTRL: assert property (
        (wr_done && sel_ctrl && !avs_byteenable[0]) |=> $stable(keypad_blank)
    ) else $error("control write without lane 0 took effect");

    AST_RECAPTURE_PULSE: assert property (
        (wr_ctrl && avs_writedata[`PHW_CTRL_RECAPTURE]) |=> sif.capture
    ) else $error("recapture request did not capture straps");

    AST_RECAPTURE_SELF_CLEAR: assert property (
        recapture |=> !recapture
    ) else $error("recapture pulse stood for more than one cycle");

    AST_BLANK_SPACES: assert property (
        keypad_blank |=> operator_keypad == {4{`PHW_ASCII_SPACE}}
    ) else $error("blanked keypad does not show spaces");

    AST_PORT_FOLLOWS: assert property (
        1'b1 |=> power_hardware_identity_word == $past(sif.word)
    ) else $error("identity word port does not follow captured word");

    AST_LIVE_PREFIX: assert property (
        sif.live[`PHW_PREFIX_HI:`PHW_PREFIX_LO] == `PHW_PREFIX
    ) else $error("live word prefix is not 110");
endmodule : phw_power_id

// ===== tb/phw_power_id_tb.sv
`timescale 1ns/1ps
module phw_power_id_tb;
    import phw_pkg::*;
    logic core_clk;
    logic arst_n;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [12:0] straps;
    logic [6:0] odd_cur;
    phw_word_t id_word;
    phw_chars_t keys;
    logic [3:0] be;
    int failures;
    int compares;
    logic [12:0] table_s [4] = '{13'h0000, 13'h1f7f, 13'h0a6a, 13'h1525};
    logic [31:0] q;
    phw_word_t exp_w;

    phw_power_id #(.ADDR_W(5)) dut (
        .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .braking_switch_fitted(straps[12]),
        .dc_special_fitted(straps[11]), .conv24_fitted(straps[10]),
        .safety_relay_fitted(straps[9]), .interference_filter_fitted(straps[8]),
        .voltage_class(straps[7:6]), .normal_duty_current_code(straps[5:0]),
        .power_hardware_identity_word(id_word), .operator_keypad(keys)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    function automatic phw_word_t word_of(input logic [12:0] s);
        return {3'b110, ~s[12], s[11], ~s[10], s[9], s[8], s[7:0]};
    endfunction : word_of

    function automatic phw_chars_t keys_of(input phw_word_t w);
        phw_chars_t c;
        for (int i = 0; i < 4; i++) begin
            c[i*8 +: 8] = (w[i*4 +: 4] < 4'ha) ? 8'h30 + w[i*4 +: 4] : 8'h37 + w[i*4 +: 4];
        end
        return c;
    endfunction : keys_of

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One Avalon access; called just after a rising edge
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        logic w;
        n = 0;
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge core_clk);
        w = avs_waitrequest;
        while (w && n < 20) begin
            @(posedge core_clk);
            w = avs_waitrequest;
            n++;
        end
        rd = avs_readdata;
        if (w) begin
            failures++;
            $display("ERROR waitrequest expected 0 seen 1");
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    task automatic recapture();
        logic [31:0] dummy;
        bus(1'b1, 5'h04, 32'h1, dummy);
        repeat (4) @(posedge core_clk);
    endtask : recapture

    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        complete_run();
    end

    initial begin
        failures = 0;
        compares = 0;
        arst_n = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        be = 4'hf;
        straps = table_s[1];
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        bus(1'b0, 5'h00, 32'h0, q);
        check("id after reset", q, {16'h0, word_of(table_s[1])});
        bus(1'b1, 5'h08, 32'h3, q);
        $display("test reset capture done");
        // Every strap both ways, both voltage classes
        foreach (table_s[i]) begin
            straps <= table_s[i];
            @(posedge core_clk);
            recapture();
            exp_w = word_of(table_s[i]);
            bus(1'b0, 5'h00, 32'h0, q);
            check("id read", q, {16'h0, exp_w});
            check("id port", {16'h0, id_word}, {16'h0, exp_w});
            check("keypad", keys, keys_of(exp_w));
        end
        $display("test strap fields done");
        bus(1'b1, 5'h00, 32'hffffffff, q);
        bus(1'b0, 5'h00, 32'h0, q);
        check("id after write", q, {16'h0, exp_w});
        check("id port after write", {16'h0, id_word}, {16'h0, exp_w});
        bus(1'b0, 5'h08, 32'h0, q);
        check("status write reject", q, 32'h1);
        bus(1'b0, 5'h10, 32'h0, q);
        check("unmapped read", q, 32'h0);
        bus(1'b0, 5'h08, 32'h0, q);
        check("status unmapped", q, 32'h3);
        bus(1'b1, 5'h08, 32'h3, q);
        $display("test write refusal done");
        straps <= table_s[2];
        repeat (3) @(posedge core_clk);
        bus(1'b0, 5'h00, 32'h0, q);
        check("id held", q, {16'h0, exp_w});
        bus(1'b0, 5'h0c, 32'h0, q);
        check("live word", q, {16'h0, word_of(table_s[2])});
        bus(1'b0, 5'h08, 32'h0, q);
        check("status mismatch", q, 32'h4);
        recapture();
        bus(1'b0, 5'h08, 32'h0, q);
        check("status match", q, 32'h0);
        $display("test strap hold done");
        bus(1'b1, 5'h04, 32'h2, q);
        repeat (3) @(posedge core_clk);
        check("keypad blank", keys, 32'h20202020);
        bus(1'b0, 5'h04, 32'h0, q);
        check("ctrl read", q, 32'h2);
        bus(1'b1, 5'h04, 32'h0, q);
        repeat (3) @(posedge core_clk);
        check("keypad shown", keys, keys_of(word_of(table_s[2])));
        be <= 4'he;
        bus(1'b1, 5'h04, 32'h2, q);
        be <= 4'hf;
        repeat (3) @(posedge core_clk);
        check("keypad lane ignored", keys, keys_of(word_of(table_s[2])));
        bus(1'b0, 5'h04, 32'h0, q);
        check("ctrl lane ignored", q, 32'h0);
        $display("test keypad blank done");
        complete_run();
    end
endmodule : phw_power_id_tb
